/* pkg/argf_pkg.sv */
package argf_pkg;

  // --------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------
  localparam int ARGF_VOL_W = 8;
  localparam int ARGF_IRQ_W = 5;
  localparam int ARGF_GAIN_CODE_W = 3;

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] ARGF_RAMP_CTRL = 8'h00;
  localparam logic [7:0] ARGF_EMRG_CTRL = 8'h04;
  localparam logic [7:0] ARGF_VOL_TARGET = 8'h08;
  localparam logic [7:0] ARGF_VOL_STATUS = 8'h0c;
  localparam logic [7:0] ARGF_STATUS = 8'h10;
  localparam logic [7:0] ARGF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ARGF_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ARGF_IRQ_ENABLE = 8'h1c;

  // --------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------
  localparam int ARGF_EMRG_SPEED_LSB = 6;
  localparam int ARGF_EMRG_STEP_LSB = 4;
  localparam logic [7:0] ARGF_RAMP_CTRL_RST = 8'h22;
  localparam logic [3:0] ARGF_EMRG_CTRL_RST = 4'h0;
  localparam logic [7:0] ARGF_VOL_RST = 8'h30;
  localparam logic [7:0] ARGF_VOL_MUTE = 8'hff;
  localparam logic [ARGF_IRQ_W-1:0] ARGF_IRQ_EN_RST = 5'h00;

  // Interrupt bit positions
  localparam int ARGF_IRQ_OT = 0;
  localparam int ARGF_IRQ_OC = 1;
  localparam int ARGF_IRQ_DC = 2;
  localparam int ARGF_IRQ_CLK = 3;
  localparam int ARGF_IRQ_SUP = 4;

  // --------------------------------------------------------------
  // Gain select and sample-rate codes
  // --------------------------------------------------------------
  localparam logic [2:0] ARGF_GAIN_RSVD = 3'h7;
  localparam logic [2:0] ARGF_GAIN_26_MIN = 3'h3;
  localparam logic [3:0] ARGF_FS_11K = 4'h6;
  localparam logic [3:0] ARGF_FS_88K = 4'h9;

  // Ramp control register layout, msb first
  typedef struct packed {
    logic [1:0] up_speed;
    logic [1:0] up_step;
    logic [1:0] dn_speed;
    logic [1:0] dn_step;
  } argf_ramp_cfg_s;

  // Status register layout, msb first
  typedef struct packed {
    logic [15:0] zero;
    logic spk_oe;
    logic supply_fail;
    logic silent;
    logic clk_err;
    logic [2:0] fault;
    logic sync_882k;
    logic [3:0] sw_mult;
    logic gain_26dbv;
    logic [2:0] gain_code;
  } argf_status_s;

  // Step code to volume units of 0.5 dB
  function automatic logic [3:0] argf_step_units(input logic [1:0] code);
    case (code)
      2'b00: argf_step_units = 4'h8;
      2'b01: argf_step_units = 4'h4;
      2'b10: argf_step_units = 4'h2;
      default: argf_step_units = 4'h1;
    endcase
  endfunction

  // Speed code to sample periods per step, zero means direct change
  function automatic logic [2:0] argf_speed_period(input logic [1:0] code);
    case (code)
      2'b00: argf_speed_period = 3'h1;
      2'b01: argf_speed_period = 3'h2;
      2'b10: argf_speed_period = 3'h4;
      default: argf_speed_period = 3'h0;
    endcase
  endfunction

endpackage

/* rtl/argf_amp_ctrl.sv */

module argf_amp_ctrl
  import argf_pkg::*;
#(
  parameter int GAIN_ADC_W = 8 // Width of digitized gain level
) (
  input wire logic i_clk, // System clock, 125 MHz
  input wire logic i_srst, // Synchronous reset, active high
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size, word only
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB bus ready
  output logic [31:0] o_hrdata, // AHB read data
  output logic o_hreadyout, // AHB slave ready
  output logic o_hresp, // AHB response, always OKAY
  input wire logic i_fs_tick, // One pulse per sample period
  input wire logic [3:0] i_fs_rate_code, // Sample-rate index
  input wire logic [GAIN_ADC_W-1:0] i_gain_level, // Digitized select
  input wire logic i_over_temp_error, // Die over temperature
  input wire logic i_over_current_error, // Output over current
  input wire logic i_dc_offset_error, // DC seen on outputs
  input wire logic i_master_clk_stopped, // Master clock held low
  input wire logic i_bit_clk_stopped, // Bit clock held low
  input wire logic i_frame_clock_stopped, // Frame clock held low
  input wire logic i_supply_fail, // Power supply failure
  input wire logic i_mute_control_in, // Mute line from controller
  output logic o_fault_out_n, // Fault, active low
  output logic o_speaker_oe, // Speaker outputs driven
  output logic [7:0] o_volume, // Applied volume code
  output logic o_gain_26dbv, // 1: 26 dBV, 0: 20 dBV
  output logic [3:0] o_sw_mult, // Switching multiple of sync
  output logic o_sync_882k, // 1: 88.2 kHz sync, 0: 96 kHz
  output logic o_irq // Interrupt, level
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  // All registers live in one struct, so reset and update
  // stay in one place
  typedef struct packed {
    argf_ramp_cfg_s ramp_cfg;
    logic [3:0] emrg_cfg;
    logic [7:0] target;
    logic [ARGF_IRQ_W-1:0] irq_st;
    logic [ARGF_IRQ_W-1:0] irq_en;
    logic [2:0] fault;
    logic mute_q;
    logic pend_wr;
    logic pend_rd;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic fault_n;
    logic spk_oe;
    logic [2:0] gain_code;
    logic gain_26;
    logic [3:0] sw_mult;
    logic sync_882k;
    logic irq;
  } argf_ctrl_st_s;

  // Current and next copies of the state
  argf_ctrl_st_s st;
  argf_ctrl_st_s next_st;

  // Links between the ramp engine and the control logic
  logic emerg;
  logic silent;
  logic [7:0] volume;

  // Sample rates of the 44.1 kHz family run a slower sync;
  // codes above the known rates fall back to the 96 kHz family
  function automatic logic sync_slow(input logic [3:0] code);
    sync_slow = (code >= ARGF_FS_11K) && (code <= ARGF_FS_88K);
  endfunction

  // --------------------------------------------------------------
  // Volume ramp engine
  // --------------------------------------------------------------
  // The engine moves the volume only on a sample tick. It sees
  // the emergency request directly, so a failing clock silences
  // the speaker without any help from software
  argf_vol_ramp u_ramp (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_fs_tick(i_fs_tick),
    .i_target(st.target),
    .i_cfg(st.ramp_cfg),
    .i_emerg(emerg),
    .i_emerg_speed(st.emrg_cfg[3:2]),
    .i_emerg_step(st.emrg_cfg[1:0]),
    .o_volume(volume),
    .o_silent(silent)
  );

  // Any latched fault or failing clock or supply silences the speaker.
  // Supply failure is not latched: once the supply recovers the
  // volume climbs back to its target
  assign emerg = (|st.fault) || i_supply_fail || i_master_clk_stopped ||
                 i_bit_clk_stopped || i_frame_clock_stopped;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    logic [ARGF_IRQ_W-1:0] clr;
    logic [ARGF_IRQ_W-1:0] ev;
    logic [2:0] fault_ev;
    logic clk_err;
    logic fault_clr;
    argf_status_s stat;
    // Defaults keep every local assigned on every path
    clr = '0;
    ev = '0;
    fault_ev = '0;
    clk_err = 1'b0;
    fault_clr = 1'b0;
    stat = '0;
    // Hold every field unless a branch below changes it
    next_st = st;
    // Any stopped audio clock is a clock error
    clk_err = i_master_clk_stopped || i_bit_clk_stopped ||
              i_frame_clock_stopped;

    // Protection faults latch here
    fault_ev = {i_dc_offset_error,
                i_over_current_error,
                i_over_temp_error};
    // Mute toggle, or a clock error once silent, clears the latch.
    // Waiting for silence keeps the reset from cutting the ramp short
    fault_clr = (st.mute_q ^ i_mute_control_in) ||
                (clk_err && silent);
    // A fault arriving during the clear still lands
    next_st.fault = (fault_clr ? 3'h0 : st.fault) | fault_ev;
    // Keep the mute level to see the next toggle
    next_st.mute_q = i_mute_control_in;
    // The pin drops in the cycle the fault latches
    next_st.fault_n = ~(|next_st.fault);

    // Gain and switching decode from top bits of the level.
    // Only three codes remain below the 26 dBV band, so the
    // lowest multiple of the 20 dBV band cannot be chosen
    next_st.gain_code = i_gain_level[GAIN_ADC_W-1 -: 3];
    next_st.gain_26 = (next_st.gain_code >= ARGF_GAIN_26_MIN) &&
                      (next_st.gain_code != ARGF_GAIN_RSVD);
    // Multiple of the sync rate, zero on the reserved code
    case (next_st.gain_code)
      3'h6: next_st.sw_mult = 4'h8;
      3'h5: next_st.sw_mult = 4'h6;
      3'h4: next_st.sw_mult = 4'h4;
      3'h3: next_st.sw_mult = 4'h2;
      3'h2: next_st.sw_mult = 4'h8;
      3'h1: next_st.sw_mult = 4'h6;
      3'h0: next_st.sw_mult = 4'h4;
      default: next_st.sw_mult = 4'h0;
    endcase
    // The sync family follows the incoming sample clock
    next_st.sync_882k = sync_slow(i_fs_rate_code);

    // Outputs stay driven until the emergency ramp reaches silence;
    // a reserved gain code holds them off at once. Supply failure
    // alone leaves them driven at mute
    next_st.spk_oe = (next_st.gain_code != ARGF_GAIN_RSVD) &&
                     !(((|st.fault) || clk_err) && silent);

    // AHB write data phase. Data follows its address by a cycle,
    // so address and direction wait in the state; writes to
    // read-only or unmapped offsets are dropped
    if (st.pend_wr) begin
      case (st.addr)
        ARGF_RAMP_CTRL: next_st.ramp_cfg = i_hwdata[7:0];
        ARGF_EMRG_CTRL: next_st.emrg_cfg =
          {i_hwdata[ARGF_EMRG_SPEED_LSB +: 2],
           i_hwdata[ARGF_EMRG_STEP_LSB +: 2]};
        ARGF_VOL_TARGET: next_st.target = i_hwdata[7:0];
        ARGF_IRQ_CLEAR: clr = i_hwdata[ARGF_IRQ_W-1:0];
        ARGF_IRQ_ENABLE: next_st.irq_en = i_hwdata[ARGF_IRQ_W-1:0];
        default: next_st.target = st.target;
      endcase
      // The data phase is over
      next_st.pend_wr = 1'b0;
    end

    // AHB read wait cycle: data built after any prior write landed
    // Status word assembled from held and live values
    stat = '0;
    stat.spk_oe = st.spk_oe;
    stat.supply_fail = i_supply_fail;
    stat.silent = silent;
    stat.clk_err = clk_err;
    stat.fault = st.fault;
    stat.sync_882k = st.sync_882k;
    stat.sw_mult = st.sw_mult;
    stat.gain_26dbv = st.gain_26;
    stat.gain_code = st.gain_code;
    // Registered read data costs one wait state but keeps the
    // live status inputs off the bus path
    if (st.pend_rd) begin
      case (st.addr)
        ARGF_RAMP_CTRL: next_st.rdata = {24'h0, st.ramp_cfg};
        ARGF_EMRG_CTRL: next_st.rdata = {24'h0, st.emrg_cfg, 4'h0};
        ARGF_VOL_TARGET: next_st.rdata = {24'h0, st.target};
        ARGF_VOL_STATUS: next_st.rdata = {24'h0, volume};
        ARGF_STATUS: next_st.rdata = stat;
        ARGF_IRQ_STATUS: next_st.rdata = {27'h0, st.irq_st};
        ARGF_IRQ_ENABLE: next_st.rdata = {27'h0, st.irq_en};
        default: next_st.rdata = 32'h0;
      endcase
      // Answer ready; hreadyout rises with the data
      next_st.pend_rd = 1'b0;
      next_st.ready = 1'b1;
    end

    // AHB address phase; writes take no wait, reads take one
    // Only NONSEQ and SEQ are taken; IDLE and BUSY change nothing
    if (i_hsel && i_hready && i_htrans[1]) begin
      next_st.addr = i_haddr[7:0];
      next_st.pend_wr = i_hwrite;
      next_st.pend_rd = !i_hwrite;
      // A read pulls hreadyout low for its wait state
      next_st.ready = i_hwrite;
    end

    // Sticky interrupt status; a new event beats its clear
    ev = '0;
    ev[ARGF_IRQ_OT] = i_over_temp_error;
    ev[ARGF_IRQ_OC] = i_over_current_error;
    ev[ARGF_IRQ_DC] = i_dc_offset_error;
    // Clock and supply bits set from their levels every cycle and stay set until cleared
    ev[ARGF_IRQ_CLK] = clk_err;
    ev[ARGF_IRQ_SUP] = i_supply_fail;
    next_st.irq_st = (st.irq_st & ~clr) | ev;
    // Built from the next status, so it rises with its cause
    next_st.irq = |(next_st.irq_st & next_st.irq_en);
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset leaves the speaker undriven until the code is known
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '{ramp_cfg: ARGF_RAMP_CTRL_RST,
              emrg_cfg: ARGF_EMRG_CTRL_RST,
              target: ARGF_VOL_RST,
              irq_st: '0,
              irq_en: ARGF_IRQ_EN_RST,
              fault: 3'h0,
              mute_q: 1'b0,
              pend_wr: 1'b0,
              pend_rd: 1'b0,
              addr: 8'h00,
              rdata: 32'h0,
              ready: 1'b1,
              fault_n: 1'b1,
              spk_oe: 1'b0,
              gain_code: 3'h0,
              gain_26: 1'b0,
              sw_mult: 4'h0,
              sync_882k: 1'b0,
              irq: 1'b0};
    end else begin
      // Normal update on every clock
      st <= next_st;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Outputs come straight from the state register; the response
  // is a constant OKAY since no access is ever refused
  assign o_hrdata = st.rdata;
  assign o_hreadyout = st.ready;
  assign o_hresp = 1'b0;
  assign o_fault_out_n = st.fault_n;
  assign o_speaker_oe = st.spk_oe;
  assign o_volume = volume;
  assign o_gain_26dbv = st.gain_26;
  assign o_sw_mult = st.sw_mult;
  assign o_sync_882k = st.sync_882k;
  assign o_irq = st.irq;

endmodule

/* rtl/argf_vol_ramp.sv */
module argf_vol_ramp
  import argf_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_srst, // Synchronous reset
  input wire logic i_fs_tick, // One pulse per sample period
  input wire logic [7:0] i_target, // Requested volume code
  input wire argf_pkg::argf_ramp_cfg_s i_cfg, // Normal ramp settings
  input wire logic i_emerg, // Emergency ramp to silence
  input wire logic [1:0] i_emerg_speed, // Emergency speed code
  input wire logic [1:0] i_emerg_step, // Emergency step code
  output logic [7:0] o_volume, // Applied volume code
  output logic o_silent // Applied volume is mute
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] vol;
    logic [1:0] div;
    logic silent;
  } argf_ramp_st_s;

  argf_ramp_st_s st;
  argf_ramp_st_s next_st;

  // Step selection and clamped stepping; larger code is quieter
  always_comb begin
    logic [7:0] tgt;
    logic [1:0] spd;
    logic [1:0] stp;
    logic [2:0] per;
    logic [7:0] units;
    logic [7:0] gap;
    tgt = i_emerg ? ARGF_VOL_MUTE : i_target;
    spd = i_cfg.dn_speed;
    stp = i_cfg.dn_step;
    if (i_emerg) begin
      spd = i_emerg_speed;
      stp = i_emerg_step;
    end else if (st.vol > tgt) begin
      spd = i_cfg.up_speed;
      stp = i_cfg.up_step;
    end
    per = argf_speed_period(spd);
    units = {4'h0, argf_step_units(stp)};
    gap = (st.vol > tgt) ? (st.vol - tgt) : (tgt - st.vol);
    next_st = st;
    if (st.vol == tgt) begin
      next_st.div = 2'h0;
    end else if (i_fs_tick) begin
      if (per == 3'h0) begin
        next_st.vol = tgt;
        next_st.div = 2'h0;
      end else if (({1'b0, st.div} + 3'h1) >= per) begin
        next_st.div = 2'h0;
        // Never pass the target, whatever the step
        if (gap <= units) begin
          next_st.vol = tgt;
        end else if (st.vol > tgt) begin
          next_st.vol = st.vol - units;
        end else begin
          next_st.vol = st.vol + units;
        end
      end else begin
        next_st.div = st.div + 2'h1;
      end
    end
    next_st.silent = (next_st.vol == ARGF_VOL_MUTE);
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '{vol: ARGF_VOL_RST, div: 2'h0, silent: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_volume = st.vol;
  assign o_silent = st.silent;

endmodule

/* tb/argf_amp_ctrl_asserts.sv */
module argf_amp_ctrl_asserts
  import argf_pkg::*;
#(
  parameter int GAIN_ADC_W = 8 // Select width
) (
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Reset
  input wire logic i_fs_tick, // Sample tick
  input wire logic [3:0] i_fs_rate_code, // Rate index
  input wire logic [GAIN_ADC_W-1:0] i_gain_level, // Gain select
  input wire logic i_over_temp_error, // Heat event
  input wire logic i_over_current_error, // Current event
  input wire logic i_dc_offset_error, // Offset event
  input wire logic i_master_clk_stopped, // Clock held
  input wire logic i_bit_clk_stopped, // Clock held
  input wire logic i_frame_clock_stopped, // Clock held
  input wire logic i_supply_fail, // Supply failure
  input wire logic i_mute_control_in, // Mute line
  input wire logic o_fault_out_n, // Fault, low
  input wire logic o_speaker_oe, // Outputs driven
  input wire logic [7:0] o_volume, // Applied volume
  input wire logic o_gain_26dbv, // Gain mode
  input wire logic [3:0] o_sw_mult, // Switching multiple
  input wire logic o_sync_882k // Sync family
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] code;
  logic clk_err;
  // ------------
  // Helpers
  // ------------
  // The code is the top three bits of the level
  assign code = i_gain_level[GAIN_ADC_W-1 -: 3];
  assign clk_err = i_master_clk_stopped | i_bit_clk_stopped |
    i_frame_clock_stopped;

  function automatic logic [3:0] mult(input logic [2:0] c);
    case (c)
      3'h7: mult = 4'h0;
      3'h6, 3'h2: mult = 4'h8;
      3'h5, 3'h1: mult = 4'h6;
      3'h4, 3'h0: mult = 4'h4;
      default: mult = 4'h2;
    endcase
  endfunction

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // Inputs held long enough to pass any decode register
  sequence s_code_held; $stable(code) [*3]; endsequence
  sequence s_silent_fault; (!o_fault_out_n && o_volume == 8'hff) [*2];
  endsequence

  property p_ot; i_over_temp_error |=> !o_fault_out_n; endproperty
  property p_oc; i_over_current_error |=> !o_fault_out_n; endproperty
  property p_dc; i_dc_offset_error |=> !o_fault_out_n; endproperty
  // Mute quiet for two clock cycles and no clock error: fault stays
  property p_latch;
    !o_fault_out_n && $stable(i_mute_control_in) && !clk_err &&
    i_mute_control_in == $past(i_mute_control_in, 2) && !$past(clk_err)
    |=> !o_fault_out_n;
  endproperty
  property p_decode;
    s_code_held |-> o_sw_mult == mult(code) &&
    (code == 3'h7 || o_gain_26dbv == (code >= 3'h3));
  endproperty
  property p_rsvd; s_code_held ##0 code == 3'h7 |-> !o_speaker_oe;
  endproperty
  property p_sync;
    $stable(i_fs_rate_code) [*3] |->
    o_sync_882k == (i_fs_rate_code >= 4'h6 && i_fs_rate_code <= 4'h9);
  endproperty
  property p_tick;
    !i_fs_tick && !clk_err && !$past(clk_err) |=> $stable(o_volume);
  endproperty
  property p_oe_off; s_silent_fault |-> !o_speaker_oe; endproperty
  property p_emrg;
    i_supply_fail && $past(i_supply_fail) && i_fs_tick
    |=> o_volume >= $past(o_volume);
  endproperty

  a_ot: assert property (p_ot)
    else $error("fault line high after heat event");
  a_oc: assert property (p_oc)
    else $error("fault line high after current event");
  a_dc: assert property (p_dc)
    else $error("fault line high after offset event");
  a_latch: assert property (p_latch)
    else $error("fault released without mute toggle");
  a_decode: assert property (p_decode)
    else $error("gain or switching multiple wrong");
  a_rsvd: assert property (p_rsvd)
    else $error("outputs driven on reserved code");
  a_sync: assert property (p_sync)
    else $error("sync family wrong");
  a_tick: assert property (p_tick)
    else $error("volume moved without sample tick");
  a_oe_off: assert property (p_oe_off)
    else $error("outputs driven while silent in fault");
  a_emrg: assert property (p_emrg)
    else $error("volume got louder during supply failure");
endmodule

/* tb/argf_sys_ctrl_model.sv */
module argf_sys_ctrl_model (
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Reset
  input wire logic i_clear_req, // Ask for a fault clear
  input wire logic i_stop_req, // Ask to hold the frame clock
  output logic o_mute, // Mute line to the amplifier
  output logic o_frame_stopped // Frame clock held low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------
  // Controller
  // ------------
  // Any edge on mute clears, so one toggle per request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mute <= 1'b0;
      o_frame_stopped <= 1'b0;
    end else begin
      if (i_clear_req) begin
        o_mute <= ~o_mute;
      end
      o_frame_stopped <= i_stop_req;
    end
  end
endmodule

/* tb/tb_amp_ramp_gain_fault_ctrl.sv */
module tb_amp_ramp_gain_fault_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import argf_pkg::*;
  logic i_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hw = 1'b0;
  logic tick = 1'b0;
  logic sup = 1'b0;
  logic clr = 1'b0;
  logic stop = 1'b0;
  logic [1:0] htr = 2'h0;
  logic [2:0] flt = 3'h0;
  logic [1:0] cstop = 2'h0;
  logic [3:0] rate = 4'h0;
  logic [7:0] gain = 8'hc0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwd = 32'h0;
  logic [31:0] hrd, r;
  logic hrdy, hresp, fault_n, oe, g26, sync, irq, mute, fstop;
  logic [7:0] vol, t;
  logic [7:0] ev = 8'h30;
  logic [3:0] mlt, d;
  int err_count = 0;
  int comparisons = 0;

  // Free-running system clock
  always #4 i_clk = ~i_clk;

  argf_amp_ctrl dut (
    .i_clk(i_clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htr), .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(hwd),
    .i_hready(hrdy), .o_hrdata(hrd), .o_hreadyout(hrdy),
    .o_hresp(hresp), .i_fs_tick(tick), .i_fs_rate_code(rate),
    .i_gain_level(gain), .i_over_temp_error(flt[0]),
    .i_over_current_error(flt[1]), .i_dc_offset_error(flt[2]),
    .i_master_clk_stopped(cstop[0]), .i_bit_clk_stopped(cstop[1]),
    .i_frame_clock_stopped(fstop), .i_supply_fail(sup),
    .i_mute_control_in(mute), .o_fault_out_n(fault_n),
    .o_speaker_oe(oe), .o_volume(vol), .o_gain_26dbv(g26),
    .o_sw_mult(mlt), .o_sync_882k(sync), .o_irq(irq));

  argf_sys_ctrl_model u_ctrl (.i_clk(i_clk), .i_srst(srst),
    .i_clear_req(clr), .i_stop_req(stop), .o_mute(mute),
    .o_frame_stopped(fstop));

  // ------------
  // Expectations and bus tasks
  // ------------
  function automatic logic [3:0] units(input logic [1:0] c);
    units = 4'h8 >> c;
  endfunction
  // Upper band counts down from x8, lower band from x8 too
  function automatic logic [3:0] em(input logic [2:0] c);
    em = (c == 3'h7) ? 4'h0 : (c >= 3'h3) ? 4'(2 * (c - 3) + 2)
      : 4'(2 * c + 4);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", comparisons,
      err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // The slave may insert wait states, so never assume a count
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("mismatch hready exp 1 got %b", hrdy);
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htr <= 2'h2;
    hw <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= wd;
    wait_rdy();
    r = hrd;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      tick <= 1'b1;
      cyc(1);
      tick <= 1'b0;
      cyc(3);
    end
  endtask

  // ------------
  // Main sequence
  // ------------
  initial begin
    void'($urandom(10739));
    cyc(20);
    srst <= 1'b0;
    cyc(2);
    chk("fault_n", 1, fault_n);
    chk("volume", 8'h30, vol);
    rdc(ARGF_RAMP_CTRL, 32'h22);
    rdc(ARGF_EMRG_CTRL, 32'h0);
    rdc(8'h40, 32'h0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      gain <= {3'(c), 5'($urandom)};
      cyc(4);
      chk("sw_mult", em(3'(c)), mlt);
      if (c != 7) chk("gain", c >= 3, g26);
      else chk("oe reserved", 0, oe);
    end
    for (int k = 0; k < 10; k++) begin
      rate <= 4'(k);
      cyc(4);
      chk("sync", k >= 6, sync);
    end
    gain <= 8'hc0;
    cyc(4);
    chk("oe", 1, oe);
    $display("test decode done");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, ARGF_RAMP_CTRL, {24'h0, 2'b00, 2'(3 - s), 2'b00, 2'(s)});
      d = 4'(9 + $urandom_range(3));
      t = ev + 8'(d);
      bus(1'b1, ARGF_VOL_TARGET, {24'h0, t});
      tk(1);
      chk("step down", ev + 8'(units(2'(s))), vol);
      tk(12);
      chk("clamp down", t, vol);
      bus(1'b1, ARGF_VOL_TARGET, {24'h0, ev});
      tk(1);
      chk("step up", t - 8'(units(2'(3 - s))), vol);
      tk(12);
      chk("clamp up", ev, vol);
    end
    bus(1'b1, ARGF_RAMP_CTRL, 32'hcc);
    bus(1'b1, ARGF_VOL_TARGET, 32'h60);
    tk(1);
    chk("direct", 8'h60, vol);
    bus(1'b1, ARGF_VOL_TARGET, 32'h30);
    tk(1);
    $display("test ramp done");
    bus(1'b1, ARGF_IRQ_ENABLE, 32'h1f);
    for (int f = 0; f < 3; f++) begin
      flt <= 3'(1 << f);
      cyc(1);
      flt <= 3'h0;
      cyc(2);
      chk("fault_n", 0, fault_n);
      rdc(ARGF_IRQ_STATUS, 32'(1 << f));
      chk("irq", 1, irq);
      tk(1);
      chk("emergency step", 8'h38, vol);
      tk(30);
      chk("silence", 8'hff, vol);
      chk("outputs off", 0, oe);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(3);
      chk("fault cleared", 1, fault_n);
      bus(1'b1, ARGF_IRQ_CLEAR, 32'(1 << f));
      cyc(2);
      chk("irq cleared", 0, irq);
      tk(1);
      chk("outputs on", 1, oe);
    end
    bus(1'b1, ARGF_IRQ_ENABLE, 32'h0);
    bus(1'b1, ARGF_EMRG_CTRL, 32'h10);
    sup <= 1'b1;
    cyc(2);
    tk(1);
    chk("supply step", 8'h34, vol);
    chk("irq masked", 0, irq);
    rdc(ARGF_IRQ_STATUS, 32'h10);
    sup <= 1'b0;
    cyc(2);
    tk(1);
    bus(1'b1, ARGF_IRQ_CLEAR, 32'h1f);
    $display("test fault done");
    bus(1'b1, ARGF_EMRG_CTRL, 32'hc0);
    // Frame clock through the controller, then master and bit clocks
    for (int k = 0; k < 3; k++) begin
      flt <= 3'h1;
      cyc(1);
      flt <= 3'h0;
      tk(1);
      chk("direct silence", 8'hff, vol);
      if (k == 0) stop <= 1'b1;
      else cstop <= 2'(k);
      cyc(4);
      chk("clock error clear", 1, fault_n);
      stop <= 1'b0;
      cstop <= 2'h0;
      cyc(2);
      tk(110);
      chk("restart volume", 8'h30, vol);
      chk("restart outputs", 1, oe);
    end
    $display("test clock error done");
    give_verdict();
  end
endmodule

bind argf_amp_ctrl argf_amp_ctrl_asserts #(.GAIN_ADC_W(GAIN_ADC_W)) u_chk (
  .i_clk, .i_srst, .i_fs_tick, .i_fs_rate_code, .i_gain_level,
  .i_over_temp_error, .i_over_current_error, .i_dc_offset_error,
  .i_master_clk_stopped, .i_bit_clk_stopped, .i_frame_clock_stopped,
  .i_supply_fail, .i_mute_control_in, .o_fault_out_n, .o_speaker_oe,
  .o_volume, .o_gain_26dbv, .o_sw_mult, .o_sync_882k);
